// ==== cmb_msgbuf_ctrl.sv ====
// Message buffer configuration, identifier and control registers with reception storing
// Summary of operation
// RULE1: No overwrite: unread buffer drops new data
// RULE2: Overwrite enabled: store data despite unread flag
// RULE3: Matching remote frame stored when remote/request clear
// RULE4: Transmit buffer sends remote frame if bit set
// RULE5: Remote reception leaves remote-request bit zero
// RULE6: Remote-request set: matching remote frame not stored
// RULE7: Type field picks transmit or receive mask
// RULE8: Unused buffers take no part in operation
// RULE9: Software writes zero to config bits 2,1
// RULE10: Config register accessed as bytes
// RULE11: Format bit picks 11- or 29-bit identifier
// RULE12: Software left-aligns standard identifiers
// RULE13: Software writes zero to id-high bits 14,13
// RULE14: Identifier and control registers are 16-bit units
// RULE15: Reset clears control register to zero
// RULE16: Update flag high while storing received frame
// RULE17: Overwrite flag set only on data overwrite
// RULE18: Interrupt enable gates completion requests
// RULE19: New-data flag set on every store
// RULE20: Transmit request shows pending or active frame
// RULE21: Ready bit locks buffer against software
// RULE22: Paired set/clear bits update control flags
// RULE23: Software never sets the new-data flag
// RULE24: Reception considers assigned, ready, matching buffers only
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "cmb_consts.svh"

module cmb_msgbuf_ctrl
    import cmb_pkg::*;
#(
    parameter int NBUF = 8,
    parameter int BW = 3,
    parameter int PAW = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PAW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [28:0] mask1_id,
    input wire logic [28:0] mask2_id,
    input wire logic [28:0] mask3_id,
    input wire logic [28:0] mask4_id,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [28:0] rx_id,
    input wire logic rx_ide,
    input wire logic rx_remote,
    input wire logic [3:0] rx_dlc,
    output logic store_strobe,
    output logic [BW-1:0] store_buf,
    output logic [3:0] store_dlc,
    output logic store_remote,
    output logic rx_drop,
    input wire logic tx_done,
    input wire logic [BW-1:0] tx_done_buf,
    output logic [NBUF-1:0] tx_pending,
    output logic [NBUF-1:0] tx_remote,
    output logic irq_rx_req,
    output logic irq_tx_req,
    output logic [BW-1:0] irq_buf
);
    // Refuse sizes the address decode cannot serve
    if (NBUF < 1 || NBUF > 32 || (1 << BW) < NBUF || PAW < BW + `CMB_SLOT_LSB) begin : g_bad_param
        $error("cmb_msgbuf_ctrl: NBUF, BW or PAW out of range");
    end

    // Per-buffer register storage
    logic [7:0] cfg_r [NBUF];
    logic [15:0] idl_r [NBUF];
    logic [15:0] idh_r [NBUF];
    // Control flags, one bit per buffer
    logic [NBUF-1:0] muc_r;
    logic [NBUF-1:0] mow_r;
    logic [NBUF-1:0] ie_r;
    logic [NBUF-1:0] dn_r;
    logic [NBUF-1:0] trq_r;
    logic [NBUF-1:0] rdy_r;

    // Storing sequence state and latched frame
    cmb_state_t state_r;
    cmb_state_t state_nxt;
    logic [BW-1:0] tgt_r;
    logic tgt_remote_r;
    logic [3:0] tgt_dlc_r;
    // Read data and error for the access
    logic [31:0] rdata_r;
    logic err_r;

    // Lone set sets, lone clear clears
    function automatic logic pair_upd(input logic cur, input logic set_b, input logic clr_b);
        if (set_b && !clr_b) begin
            pair_upd = 1'b1;
        end else if (!set_b && clr_b) begin
            pair_upd = 1'b0;
        end else begin
            pair_upd = cur;
        end
    endfunction

    // Buffer type of one slot
    function automatic cmb_buf_type_t type_of(input logic [7:0] cfg);
        type_of = cfg[`CMB_CFG_TYPE_MSB:`CMB_CFG_TYPE_LSB];
    endfunction

    // Bus decode
    logic [BW-1:0] a_buf;
    logic [3:0] a_reg;
    logic a_hit;
    logic lane8_ok;
    logic lane16_ok;
    logic setup_ph;
    logic wr_acc;
    logic wr_ok;

    assign a_buf = paddr[`CMB_SLOT_LSB +: BW];
    assign a_reg = paddr[3:0];
    // Upper bits zero and slot present
    assign a_hit = (paddr >> (`CMB_SLOT_LSB + BW)) == '0 && int'(a_buf) < NBUF;
    // RULE10 byte access
    assign lane8_ok = pstrb[0];
    // RULE14 halfword access
    assign lane16_ok = pstrb[1:0] == 2'b11;
    assign setup_ph = psel && !penable;
    // No transfer completes while frozen
    assign pready = pce;
    assign wr_acc = psel && penable && pwrite && pce;
    assign wr_ok = wr_acc && !err_r;
    assign pslverr = psel && penable && err_r;
    assign prdata = rdata_r;

    // Unmapped address or too narrow a write
    logic dec_err;
    always_comb begin
        if (!a_hit) begin
            dec_err = 1'b1;
        end else if (a_reg == `CMB_OFF_CONFIG) begin
            dec_err = pwrite && !lane8_ok;
        end else if (a_reg == `CMB_OFF_ID_LOW || a_reg == `CMB_OFF_ID_HIGH || a_reg == `CMB_OFF_CONTROL) begin
            dec_err = pwrite && !lane16_ok;
        end else begin
            dec_err = 1'b1;
        end
    end

    // Read view of the selected register, upper bits zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        if (a_hit) begin
            if (a_reg == `CMB_OFF_CONFIG) begin
                rd_mux = {24'h000000, cfg_r[a_buf]};
            end else if (a_reg == `CMB_OFF_ID_LOW) begin
                rd_mux = {16'h0000, idl_r[a_buf]};
            end else if (a_reg == `CMB_OFF_ID_HIGH) begin
                rd_mux = {16'h0000, idh_r[a_buf]};
            end else if (a_reg == `CMB_OFF_CONTROL) begin
                rd_mux[`CMB_CTL_MUC] = muc_r[a_buf];
                rd_mux[`CMB_CTL_MOW] = mow_r[a_buf];
                rd_mux[`CMB_CTL_IE] = ie_r[a_buf];
                rd_mux[`CMB_CTL_DN] = dn_r[a_buf];
                rd_mux[`CMB_CTL_TRQ] = trq_r[a_buf];
                rd_mux[`CMB_CTL_RDY] = rdy_r[a_buf];
            end
        end
    end

    // Read data and error captured at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h00000000;
            err_r <= 1'b0;
        end else if (pce && setup_ph) begin
            rdata_r <= pwrite ? 32'h00000000 : rd_mux;
            err_r <= dec_err;
        end
    end

    // Reception search
    logic [NBUF-1:0] cand;
    logic pick_found;
    logic [BW-1:0] pick_idx;
    logic pick_locked;

    // Mask selection for the receive types
    function automatic logic [28:0] mask_of(input cmb_buf_type_t t, input logic [28:0] m1,
                                            input logic [28:0] m2, input logic [28:0] m3,
                                            input logic [28:0] m4);
        case (t)
            `CMB_TYPE_RX_MASK1: mask_of = m1;
            `CMB_TYPE_RX_MASK2: mask_of = m2;
            `CMB_TYPE_RX_MASK3: mask_of = m3;
            `CMB_TYPE_RX_MASK4: mask_of = m4;
            default: mask_of = 29'h0000000;
        endcase
    endfunction

    for (genvar g = 0; g < NBUF; g++) begin : g_match
        logic id_hit;
        cmb_buf_type_t btype;
        logic is_rx_type;
        logic is_tx_type;
        assign btype = type_of(cfg_r[g]);
        // RULE7 legal type codes only; prohibited codes never take part
        assign is_tx_type = btype == `CMB_TYPE_TX;
        assign is_rx_type = btype >= `CMB_TYPE_RX_NOMASK && btype <= `CMB_TYPE_RX_MASK4;

        // RULE11 format-aware identifier compare
        cmb_id_match u_match (
            .buf_id({idh_r[g][12:0], idl_r[g]}),
            .buf_ide(idh_r[g][`CMB_IDH_IDE]),
            .rx_id(rx_id),
            .rx_ide(rx_ide),
            .mask_id(mask_of(btype, mask1_id, mask2_id, mask3_id, mask4_id)),
            .use_mask(btype != `CMB_TYPE_RX_NOMASK),
            .hit(id_hit)
        );

        // RULE24 assigned, ready, matching buffers only
        // RULE8 unused buffers excluded
        // RULE3 remote frame into transmit buffer with both bits clear
        // RULE6 remote-request set blocks remote storage
        always_comb begin
            if (!cfg_r[g][`CMB_CFG_IN_USE] || !rdy_r[g] || !id_hit) begin
                cand[g] = 1'b0;
            end else if (rx_remote) begin
                cand[g] = is_tx_type && !cfg_r[g][`CMB_CFG_RTR] && !trq_r[g];
            end else begin
                cand[g] = is_rx_type;
            end
        end

        // RULE4 frame kind offered for transmission
        assign tx_remote[g] = cfg_r[g][`CMB_CFG_RTR];
        // RULE20 pending request of a live transmit buffer
        assign tx_pending[g] = trq_r[g] && rdy_r[g] && cfg_r[g][`CMB_CFG_IN_USE] && is_tx_type;
    end

    cmb_prio_pick #(
        .N(NBUF),
        .BW(BW)
    ) u_pick (
        .req(cand),
        .found(pick_found),
        .index(pick_idx)
    );

    // RULE1 unread data, no overwrite: discard
    // RULE2 overwrite permission lets the store go ahead
    assign pick_locked = !rx_remote && dn_r[pick_idx] && !cfg_r[pick_idx][`CMB_CFG_OWS];

    // No new frame while storing
    assign rx_ready = state_r == CMB_ST_IDLE;

    logic rx_take;
    logic start_store;
    logic commit;
    assign rx_take = pce && rx_valid && state_r == CMB_ST_IDLE;
    assign start_store = rx_take && pick_found && !pick_locked;
    // Software may drop ready mid-store; the store is then abandoned
    assign commit = pce && state_r == CMB_ST_STORE && rdy_r[tgt_r];

    // One STORE cycle with the update flag high
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CMB_ST_IDLE: begin
                if (start_store) begin
                    state_nxt = CMB_ST_STORE;
                end
            end
            CMB_ST_STORE: begin
                state_nxt = CMB_ST_IDLE;
            end
            default: begin
                state_nxt = CMB_ST_IDLE;
            end
        endcase
    end

    // State register and latched target
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= CMB_ST_IDLE;
            tgt_r <= '0;
            tgt_remote_r <= 1'b0;
            tgt_dlc_r <= 4'h0;
        end else if (pce) begin
            state_r <= state_nxt;
            if (start_store) begin
                tgt_r <= pick_idx;
                tgt_remote_r <= rx_remote;
                tgt_dlc_r <= rx_dlc;
            end
        end
    end

    // Commit strobe for data and history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            store_strobe <= 1'b0;
            store_buf <= '0;
            store_dlc <= 4'h0;
            store_remote <= 1'b0;
            rx_drop <= 1'b0;
        end else if (pce) begin
            store_strobe <= commit;
            rx_drop <= rx_take && !start_store;
            if (commit) begin
                store_buf <= tgt_r;
                store_dlc <= tgt_dlc_r;
                store_remote <= tgt_remote_r;
            end
        end
    end

    // Completion interrupt requests, gated per buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_rx_req <= 1'b0;
            irq_tx_req <= 1'b0;
            irq_buf <= '0;
        end else if (pce) begin
            // RULE18 enable bit gates the completion request
            irq_rx_req <= commit && ie_r[tgt_r];
            irq_tx_req <= tx_done && ie_r[tx_done_buf] && !(commit && ie_r[tgt_r]);
            if (commit) begin
                irq_buf <= tgt_r;
            end else if (tx_done) begin
                irq_buf <= tx_done_buf;
            end
        end
    end

    // Software writes to configuration and identifier
    // Reset clear keeps stray buffers from matching
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NBUF; i++) begin
                cfg_r[i] <= `CMB_CFG_RESET;
                idl_r[i] <= `CMB_ID_RESET;
                idh_r[i] <= `CMB_ID_RESET;
            end
        // RULE21 ready buffers ignore these writes
        end else if (wr_ok && !rdy_r[a_buf]) begin
            // RULE5 remote reception never writes the remote-request bit
            if (a_reg == `CMB_OFF_CONFIG) begin
                // RULE9 bits 2 and 1 held at zero
                cfg_r[a_buf] <= pwdata[7:0] & `CMB_CFG_WMASK;
            end else if (a_reg == `CMB_OFF_ID_LOW) begin
                idl_r[a_buf] <= pwdata[15:0];
            end else if (a_reg == `CMB_OFF_ID_HIGH) begin
                // RULE13 bits 14 and 13 held at zero
                idh_r[a_buf] <= pwdata[15:0] & `CMB_IDH_WMASK;
            end
        end
    end

    // Control flags
    logic [NBUF-1:0] ctl_wr;
    always_comb begin
        for (int i = 0; i < NBUF; i++) begin
            ctl_wr[i] = wr_ok && a_reg == `CMB_OFF_CONTROL && int'(a_buf) == i;
        end
    end

    // Ready and request pairs act even when locked
    // RULE15 all flags clear on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_r <= '0;
            trq_r <= '0;
        end else if (pce) begin
            for (int i = 0; i < NBUF; i++) begin
                // RULE22 paired set and clear
                if (ctl_wr[i]) begin
                    rdy_r[i] <= pair_upd(rdy_r[i], pwdata[`CMB_WR_SET_RDY], pwdata[`CMB_WR_CLR_RDY]);
                end
                // RULE20 done clears; software set wins
                if (ctl_wr[i] && (pwdata[`CMB_WR_SET_TRQ] || pwdata[`CMB_WR_CLR_TRQ])) begin
                    trq_r[i] <= pair_upd(trq_r[i], pwdata[`CMB_WR_SET_TRQ], pwdata[`CMB_WR_CLR_TRQ]);
                end else if (tx_done && int'(tx_done_buf) == i) begin
                    trq_r[i] <= 1'b0;
                end
            end
        end
    end

    // Enable writable only while not ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie_r <= '0;
        end else if (pce) begin
            for (int i = 0; i < NBUF; i++) begin
                // RULE21 lock blocks the enable bit
                if (ctl_wr[i] && !rdy_r[i]) begin
                    ie_r[i] <= pair_upd(ie_r[i], pwdata[`CMB_WR_SET_IE], pwdata[`CMB_WR_CLR_IE]);
                end
            end
        end
    end

    // Hardware sets, software only clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dn_r <= '0;
            mow_r <= '0;
        end else if (pce) begin
            for (int i = 0; i < NBUF; i++) begin
                // RULE19 store sets; beats same-cycle clear
                // RULE23 the set position of the write is ignored
                if (commit && int'(tgt_r) == i) begin
                    dn_r[i] <= 1'b1;
                end else if (ctl_wr[i] && pwdata[`CMB_WR_CLR_DN]) begin
                    dn_r[i] <= 1'b0;
                end
                // RULE17 data on unread data overwrites
                if (commit && int'(tgt_r) == i && !tgt_remote_r && dn_r[i]) begin
                    mow_r[i] <= 1'b1;
                end else if (ctl_wr[i] && pwdata[`CMB_WR_CLR_MOW]) begin
                    mow_r[i] <= 1'b0;
                end
            end
        end
    end

    // Update flag follows the store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            muc_r <= '0;
        end else if (pce) begin
            for (int i = 0; i < NBUF; i++) begin
                // RULE16 high only during the store cycle
                muc_r[i] <= state_nxt == CMB_ST_STORE && start_store && pick_idx == BW'(i);
            end
        end
    end
endmodule
`default_nettype wire

// ==== cmb_consts.svh ====
// Offsets, fields and reset values of the message buffer block
`ifndef CMB_CONSTS_SVH
`define CMB_CONSTS_SVH

// Byte offsets of the registers inside one buffer's 16-byte slot
`define CMB_OFF_CONFIG 4'h0
`define CMB_OFF_ID_LOW 4'h4
`define CMB_OFF_ID_HIGH 4'h8
`define CMB_OFF_CONTROL 4'hc
// 16-byte slots: buffer index from address bit 4
`define CMB_SLOT_LSB 4

// msgbuf_config fields
`define CMB_CFG_OWS 7
`define CMB_CFG_RTR 6
`define CMB_CFG_TYPE_MSB 5
`define CMB_CFG_TYPE_LSB 3
`define CMB_CFG_IN_USE 0
// Bits 2 and 1 always read zero
`define CMB_CFG_WMASK 8'hf9
`define CMB_CFG_RESET 8'h00

// msgbuf_id_high fields
`define CMB_IDH_IDE 15
// Bits 14 and 13 always read zero
`define CMB_IDH_WMASK 16'h9fff
`define CMB_ID_RESET 16'h0000
// Standard identifiers sit in id[28:18]
`define CMB_STD_ID_LSB 18

// msgbuf_control read layout
`define CMB_CTL_MUC 13
`define CMB_CTL_MOW 4
`define CMB_CTL_IE 3
`define CMB_CTL_DN 2
`define CMB_CTL_TRQ 1
`define CMB_CTL_RDY 0

// msgbuf_control write layout (set and clear pairs)
`define CMB_WR_SET_IE 11
`define CMB_WR_SET_DN 10
`define CMB_WR_SET_TRQ 9
`define CMB_WR_SET_RDY 8
`define CMB_WR_CLR_MOW 4
`define CMB_WR_CLR_IE 3
`define CMB_WR_CLR_DN 2
`define CMB_WR_CLR_TRQ 1
`define CMB_WR_CLR_RDY 0

// Buffer type codes
`define CMB_TYPE_TX 3'h0
`define CMB_TYPE_RX_NOMASK 3'h1
`define CMB_TYPE_RX_MASK1 3'h2
`define CMB_TYPE_RX_MASK2 3'h3
`define CMB_TYPE_RX_MASK3 3'h4
`define CMB_TYPE_RX_MASK4 3'h5

`endif

// ==== cmb_pkg.sv ====
// Types shared by the message buffer block
package cmb_pkg;
    // Buffer type field
    typedef logic [2:0] cmb_buf_type_t;
    // Reception storing sequence
    typedef enum logic [0:0] {
        CMB_ST_IDLE,
        CMB_ST_STORE
    } cmb_state_t;
endpackage

// ==== cmb_id_match.sv ====
// Identifier comparison of one buffer against a received frame
`timescale 1ns/1ps
`default_nettype none
`include "cmb_consts.svh"

module cmb_id_match (
    input wire logic [28:0] buf_id,
    input wire logic buf_ide,
    input wire logic [28:0] rx_id,
    input wire logic rx_ide,
    input wire logic [28:0] mask_id,
    input wire logic use_mask,
    output logic hit
);
    // Bits where the two identifiers agree or are ignored
    logic [28:0] same;
    // Bits ignored because the format is standard
    logic [28:0] std_skip;

    // 11- or 29-bit compare; mask bits of 1 ignore
    always_comb begin
        std_skip = buf_ide ? 29'h0000000 : {11'h000, {`CMB_STD_ID_LSB{1'b1}}};
        same = ~(buf_id ^ rx_id) | std_skip | (use_mask ? mask_id : 29'h0000000);
        // Format must match exactly, never masked
        hit = (buf_ide == rx_ide) && (&same);
    end
endmodule
`default_nettype wire

// ==== cmb_prio_pick.sv ====
// Lowest-index selection among requesting buffers
`timescale 1ns/1ps
`default_nettype none

module cmb_prio_pick #(
    parameter int N = 8,
    parameter int BW = 3
) (
    input wire logic [N-1:0] req,
    output logic found,
    output logic [BW-1:0] index
);
    // Scan from the top so the lowest index wins
    always_comb begin
        found = 1'b0;
        index = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                index = BW'(i);
            end
        end
    end
endmodule
`default_nettype wire

// ==== cmb_msgbuf_ctrl_monitor.sv ====
// Checker on the message buffer block's ports
`timescale 1ns/1ps
`default_nettype none
module cmb_msgbuf_ctrl_monitor #(
    parameter int NBUF = 8,
    parameter int BW = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic rx_drop,
    input wire logic store_strobe,
    input wire logic [BW-1:0] store_buf,
    input wire logic store_remote,
    input wire logic tx_done,
    input wire logic [BW-1:0] tx_done_buf,
    input wire logic [NBUF-1:0] tx_pending,
    input wire logic [NBUF-1:0] tx_remote,
    input wire logic irq_rx_req,
    input wire logic irq_tx_req,
    input wire logic [BW-1:0] irq_buf
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Frame taken
    sequence s_take;
        rx_valid && rx_ready && pce;
    endsequence
    // Take that starts a store
    sequence s_store;
        s_take ##1 !rx_ready;
    endsequence
    a_take_resolves: assert property (s_take |=> rx_drop || !rx_ready)
        else $error("taken frame neither stored nor dropped");
    a_store_commits: assert property (s_store |=> store_strobe)
        else $error("store did not commit");
    a_drop_quiet: assert property (s_take ##1 rx_drop |=> !store_strobe)
        else $error("dropped frame was committed");
    a_strobe_pulse: assert property (store_strobe |=> !store_strobe)
        else $error("store strobe longer than one cycle");
    a_remote_rtr: assert property (store_strobe && store_remote |-> !tx_remote[store_buf])
        else $error("remote stored into remote sender");
    a_rx_irq_src: assert property (irq_rx_req |-> store_strobe && irq_buf == store_buf)
        else $error("rx interrupt without commit");
    a_tx_irq_src: assert property (irq_tx_req |-> $past(tx_done) && irq_buf == $past(tx_done_buf))
        else $error("transmit interrupt without completion");
    a_tx_clears: assert property (tx_done |=> !tx_pending[$past(tx_done_buf)])
        else $error("request pending after done");
endmodule
bind cmb_msgbuf_ctrl cmb_msgbuf_ctrl_monitor #(.NBUF(NBUF), .BW(BW)) mon_i (.*);
`default_nettype wire

// ==== cmb_can_node.sv ====
// Far-side node: offers frames, reports finished sends
`timescale 1ns/1ps
`default_nettype none
module cmb_can_node (
    input wire logic pclk,
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [28:0] rx_id,
    output logic rx_ide,
    output logic rx_remote,
    output logic [3:0] rx_dlc,
    output logic tx_done,
    output logic [2:0] tx_done_buf
);
    // Quiet bus at time zero
    initial begin
        {rx_valid, rx_ide, rx_remote, tx_done} = 4'h0;
        {rx_id, rx_dlc, tx_done_buf} = '0;
    end
    task automatic send(input logic [28:0] id, input logic ide, rem, input logic [3:0] dlc);
        int n;
        logic r;
        n = 0;
        {rx_valid, rx_id, rx_ide, rx_remote, rx_dlc} <= {1'h1, id, ide, rem, dlc};
        // Hold until an edge sees ready high, bounded
        do begin
            @(negedge pclk);
            r = rx_ready;
            @(posedge pclk);
            n++;
        end while (!r && n < 20);
        // Released fields show garbage
        {rx_valid, rx_id, rx_ide, rx_remote, rx_dlc} <= {1'h0, ~id, ~ide, ~rem, ~dlc};
    endtask
    // One-cycle completion report
    task automatic finish(input logic [2:0] b);
        {tx_done, tx_done_buf} <= {1'h1, b};
        @(posedge pclk);
        {tx_done, tx_done_buf} <= {1'h0, ~b};
    endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench of the message buffer block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lerr;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic [3:0] pstrb = '0, rx_dlc, store_dlc;
    logic [28:0] mask1_id = 29'h2, mask2_id = 29'h4, mask3_id = 29'h8, mask4_id = 29'h10, rx_id;
    logic pready, pslverr, rx_valid, rx_ready, rx_ide, rx_remote, store_strobe, store_remote, rx_drop;
    logic tx_done, irq_rx_req, irq_tx_req;
    logic [2:0] store_buf, tx_done_buf, irq_buf;
    logic [7:0] tx_pending, tx_remote;
    int errors = 0, cmp_count = 0;
    // 125 MHz clock
    always #4 pclk = ~pclk;
    cmb_msgbuf_ctrl cmb_msgbuf_ctrl_i (.pce(1'h1), .*);
    cmb_can_node cmb_can_node_i (.*);
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // One APB transfer then an idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        {psel, pwrite, paddr, pwdata, pstrb} <= {1'h1, w, a, d, s};
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        rdat = prdata;
        lerr = pslverr;
        {psel, penable} <= 2'h0;
        @(posedge pclk);
        if (n >= 16) begin
            errors++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d, 4'h3);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0, 4'h0);
        chk(rdat, e);
    endtask
    // zeros in id-high bits 14 and 13
    task automatic setid(input logic [11:0] a, input logic [28:0] x, input logic ide);
        wr(a + 12'h4, {16'h0, x[15:0]});
        wr(a + 12'h8, {16'h0, ide, 2'h0, x[28:16]});
    endtask
    // Offer a frame, check its outcome
    task automatic rx(input logic [28:0] id, input logic ide, rem, input logic [3:0] dlc, input logic st,
                      input logic [2:0] b, input logic ie);
        int n;
        n = 0;
        cmb_can_node_i.send(id, ide, rem, dlc);
        do begin
            @(negedge pclk);
            n++;
        end while (!(store_strobe | rx_drop) && n < 8);
        chk({store_strobe, rx_drop}, {st, ~st});
        if (st)
            chk({store_buf, store_dlc, store_remote, irq_rx_req}, {b, dlc, rem, ie});
        @(posedge pclk);
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rc(12'h01c, 32'h0);
        apb(1'h1, 12'h010, 32'h81, 4'h2);
        chk(lerr, 1'h1);
        apb(1'h0, 12'h080, 32'h0, 4'h0);
        chk(lerr, 1'h1);
        setid(12'h010, 29'h48c0000, 1'h0);
        wr(12'h010, 32'h09);
        wr(12'h01c, 32'h800);
        wr(12'h01c, 32'h100);
        rx(29'h48c3fff, 1'h0, 1'h0, 4'h5, 1'h1, 3'h1, 1'h1);
        rx(29'h48c0000, 1'h0, 1'h0, 4'h3, 1'h0, 3'h1, 1'h1);
        rc(12'h01c, 32'h0d);
        wr(12'h010, 32'h89);
        rc(12'h010, 32'h09);
        wr(12'h01c, 32'h101);
        rc(12'h01c, 32'h0d);
        wr(12'h01c, 32'h001);
        wr(12'h010, 32'h89);
        wr(12'h01c, 32'h100);
        rx(29'h48c0000, 1'h0, 1'h0, 4'h7, 1'h1, 3'h1, 1'h1);
        rc(12'h01c, 32'h1d);
        wr(12'h01c, 32'h014);
        rc(12'h01c, 32'h09);
        $display("test receive done");
        setid(12'h000, 29'habcdef, 1'h1);
        wr(12'h000, 32'h01);
        wr(12'h00c, 32'h800);
        wr(12'h00c, 32'h100);
        rx(29'habcdef, 1'h1, 1'h0, 4'h1, 1'h0, 3'h0, 1'h0);
        rx(29'habcdef, 1'h1, 1'h1, 4'h2, 1'h1, 3'h0, 1'h1);
        rx(29'habcdef, 1'h1, 1'h1, 4'h4, 1'h1, 3'h0, 1'h1);
        rc(12'h000, 32'h01);
        rc(12'h00c, 32'h0d);
        wr(12'h00c, 32'h200);
        chk(tx_pending[0], 1'h1);
        rx(29'habcdef, 1'h1, 1'h1, 4'h2, 1'h0, 3'h0, 1'h1);
        cmb_can_node_i.finish(3'h0);
        @(negedge pclk);
        chk({irq_tx_req, irq_buf, tx_pending[0]}, {1'h1, 3'h0, 1'h0});
        @(posedge pclk);
        wr(12'h00c, 32'h001);
        wr(12'h000, 32'h41);
        chk(tx_remote[0], 1'h1);
        wr(12'h00c, 32'h100);
        rx(29'habcdef, 1'h1, 1'h1, 4'h2, 1'h0, 3'h0, 1'h1);
        $display("test transmit done");
        for (int t = 2; t < 6; t++) begin
            setid({4'h0, t[3:0], 4'h0}, {t[4:0], 24'h0}, 1'h1);
            wr({4'h0, t[3:0], 4'h0}, {26'h0, t[2:0], 3'h1});
            wr({4'h0, t[3:0], 4'hc}, 32'h100);
            rx({t[4:0], 24'h0} ^ (29'h1 << (t - 1)), 1'h1, 1'h0, 4'h8, 1'h1, t[2:0], 1'h0);
        end
        setid(12'h070, 29'h123456, 1'h1);
        wr(12'h070, 32'h08);
        wr(12'h07c, 32'h100);
        rx(29'h123456, 1'h1, 1'h0, 4'h1, 1'h0, 3'h7, 1'h0);
        $display("test masks done");
        end_sim();
    end
endmodule
`default_nettype wire
